// file: sddc_defs.vh
/*
 * Constants for the sigma-delta clock select and decimation block:
 * register byte offsets, field positions, reset values, clock source
 * codes and decimation counts.
 * Assumes a 32-bit classic Wishbone slave with byte addressing.
 */
// Contract
// - Master clock nominally 16 MHz; rates reference it
// - Slower master clock scales all rates down
// - Mode bits 3:2 select master clock source
// - Reset selects the internal oscillator
// - Internal oscillator may drive the clock pin
// - External source taken from clock pin
// - Offer sinc5+sinc1, sinc3 and enhanced rejection; only sinc5+sinc1 and sinc3 are built
// - Filter and rate come from channel setup
// - Sinc5 fixed 250 kSPS; sinc1 averages further
// - Sinc5+sinc1 settles in one cycle at <=10k
// - Sinc3 settles after three output periods
// - Direct-map bit: bits 14:0 set sinc3 decimation
// - Direct rate is modulator rate over 32*value
`ifndef SDDC_DEFS_VH
`define SDDC_DEFS_VH

`define SDDC_ADR_MODE      8'h00
`define SDDC_ADR_CHMAP     8'h04
`define SDDC_ADR_STATUS    8'h08
`define SDDC_ADR_RES_LO    8'h0c
`define SDDC_ADR_RES_HI    8'h10
`define SDDC_ADR_FCFG_BASE 8'h20
`define SDDC_ADR_FCFG_LAST 8'h2c

`define SDDC_MODE_RST      16'h0000
`define SDDC_CHMAP_RST     8'he4
`define SDDC_FCFG_RST      16'h0019

`define SDDC_CSEL_MSB      3
`define SDDC_CSEL_LSB      2
`define SDDC_CSEL_INT      2'h0
`define SDDC_CSEL_INT_OUT  2'h1
`define SDDC_CSEL_EXT      2'h2
`define SDDC_CSEL_XTAL     2'h3

`define SDDC_FC_MAP_BIT    15
`define SDDC_FC_TYPE_MSB   14
`define SDDC_FC_TYPE_LSB   13
`define SDDC_FC_TYPE_SINC3 2'h3
`define SDDC_FC_AVG_MSB    12

`define SDDC_MCLK_NOM_KHZ  16000
`define SDDC_MOD_DIV       2
`define SDDC_SINC5_DEC     20'h00020
`define SDDC_SINC5_KSPS    250
`define SDDC_SETTLE1_KSPS  10
`define SDDC_SETTLE1_AVG   (`SDDC_SINC5_KSPS / `SDDC_SETTLE1_KSPS)
`define SDDC_SINC3_SETTLE  2'h3

`endif

// file: sddc_top.v
/*
 * Master clock source selection and decimation filter for a multiplexed
 * sigma-delta converter, with a classic Wishbone register slave.
 * Assumes clock pins and the modulator bit are synchronous to clk_i,
 * and that the channel sequencer presents the channel being converted.
 */
// The register offsets and the Wishbone slave port were left to the implementer.
`timescale 1ns/100ps
`include "sddc_defs.vh"

module sddc_top (
    input  wire        clk_i,             // System clock, 20 MHz
    input  wire        rst_i,             // Synchronous reset, high
    input  wire        cyc_i,             // Wishbone cycle
    input  wire        stb_i,             // Wishbone strobe
    input  wire        we_i,              // Wishbone write enable
    input  wire [7:0]  adr_i,             // Wishbone byte address
    input  wire [3:0]  sel_i,             // Wishbone byte selects
    input  wire [31:0] dat_i,             // Wishbone write data
    output reg  [31:0] dat_o,             // Wishbone read data
    output reg         ack_o,             // Wishbone acknowledge
    input  wire        int_osc_i,         // Internal oscillator level
    input  wire        crystal_input_pin_i, // Crystal oscillator level
    input  wire        clock_io_pin_i,    // Clock pin input level
    output reg         clock_io_pin_o,    // Clock pin output level
    output reg         clock_io_pin_oe_o, // Clock pin output enable
    input  wire        mod_bit_i,         // Modulator output bit
    input  wire [1:0]  channel_i,         // Channel being converted
    output reg         data_valid_o,      // Conversion done pulse
    output reg         settled_o          // Last result fully settled
);

    // ========================================================
    // Helpers
    // ========================================================
    function [15:0] merge16;
        input [15:0] old;
        input [31:0] dat;
        input [3:0]  sel;
        begin
            merge16 = {sel[1] ? dat[15:8] : old[15:8],
                       sel[0] ? dat[7:0]  : old[7:0]};
        end
    endfunction

    // Full byte address match for one register
    function is_at;
        input [7:0] adr;
        input [7:0] off;
        begin
            is_at = (adr == off);
        end
    endfunction

    // Filter words sit on four aligned offsets
    function fc_at;
        input [7:0] adr;
        begin
            fc_at = (adr >= `SDDC_ADR_FCFG_BASE) &&
                    (adr <= `SDDC_ADR_FCFG_LAST) &&
                    (adr[1:0] == 2'h0);
        end
    endfunction

    // ========================================================
    // Registers
    // ========================================================
    reg  [15:0] mode;
    reg  [7:0]  chmap;
    reg  [15:0] fcfg [0:3];
    reg  [63:0] result;
    reg  [1:0]  result_chan;
    reg         ready;
    reg  [31:0] next_dat;
    integer     i;

    wire        req     = cyc_i & stb_i & ~ack_o;
    wire        wr      = req & we_i;
    wire        fc_hit  = fc_at(adr_i);
    wire [1:0]  fc_idx  = adr_i[3:2];
    wire        at_mode = is_at(adr_i, `SDDC_ADR_MODE);
    wire        at_map  = is_at(adr_i, `SDDC_ADR_CHMAP);
    wire        at_lo   = is_at(adr_i, `SDDC_ADR_RES_LO);
    wire        cfg_wr  = wr && (fc_hit || at_mode || at_map);
    wire        lo_read = req & ~we_i & at_lo;
    wire [1:0]  csel    = mode[`SDDC_CSEL_MSB:`SDDC_CSEL_LSB];
    wire        emit;

    // ========================================================
    // Read data selection
    // ========================================================
    always @* begin
        case (adr_i)
            `SDDC_ADR_MODE:   next_dat = {16'h0000, mode};
            `SDDC_ADR_CHMAP:  next_dat = {24'h000000, chmap};
            `SDDC_ADR_STATUS: next_dat = {26'h0000000, result_chan,
                                          csel, settled_o, ready};
            `SDDC_ADR_RES_LO: next_dat = result[31:0];
            `SDDC_ADR_RES_HI: next_dat = result[63:32];
            default: begin
                next_dat = fc_hit ? {16'h0000, fcfg[fc_idx]} : 32'h0;
            end
        endcase
    end

    // ========================================================
    // Bus answer
    // ========================================================
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0;
        end else begin
            ack_o <= req;
            if (req) begin
                dat_o <= we_i ? 32'h0 : next_dat;
            end
        end
    end

    // ========================================================
    // Configuration registers
    // ========================================================
    always @(posedge clk_i) begin
        if (rst_i) begin
            mode  <= `SDDC_MODE_RST;
            chmap <= `SDDC_CHMAP_RST;
        end else begin
            if (wr && at_mode) begin
                mode <= merge16(mode, dat_i, sel_i);
            end
            if (wr && at_map && sel_i[0]) begin
                chmap <= dat_i[7:0];
            end
        end
    end

    // Only the two low byte lanes reach the 16-bit filter words
    always @(posedge clk_i) begin
        if (rst_i) begin
            for (i = 0; i < 4; i = i + 1) begin
                fcfg[i] <= `SDDC_FCFG_RST;
            end
        end else if (wr && fc_hit) begin
            fcfg[fc_idx] <= merge16(fcfg[fc_idx], dat_i, sel_i);
        end
    end

    // Result ready: a new result wins over a read of the low word
    always @(posedge clk_i) begin
        if (rst_i) begin
            ready <= 1'b0;
        end else if (emit) begin
            ready <= 1'b1;
        end else if (lo_read) begin
            ready <= 1'b0;
        end
    end

    // ========================================================
    // Master clock source and modulator rate
    // ========================================================
    reg         src_now;
    reg         src_q;
    reg         half;
    wire        mclk_rise = src_now & ~src_q;
    wire        mod_tick  = mclk_rise & half;

    always @* begin
        case (csel)
            `SDDC_CSEL_INT:     src_now = int_osc_i;
            `SDDC_CSEL_INT_OUT: src_now = int_osc_i;
            `SDDC_CSEL_EXT:     src_now = clock_io_pin_i;
            default:            src_now = crystal_input_pin_i;
        endcase
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            src_q             <= 1'b0;
            half              <= 1'b0;
            clock_io_pin_o    <= 1'b0;
            clock_io_pin_oe_o <= 1'b0;
        end else begin
            src_q             <= src_now;
            // Every rate counts master clock edges, so it follows it
            if (mclk_rise) begin
                half <= ~half;
            end
            clock_io_pin_o    <= int_osc_i;
            clock_io_pin_oe_o <= (csel == `SDDC_CSEL_INT_OUT);
        end
    end

    // ========================================================
    // Setup selection for the active channel
    // ========================================================
    reg  [1:0]  chan_q;
    wire [7:0]  map_sh  = chmap >> {channel_i, 1'b0};
    wire [15:0] cfg     = fcfg[map_sh[1:0]];
    wire        direct  = cfg[`SDDC_FC_MAP_BIT];
    wire        sinc3   = direct |
        (cfg[`SDDC_FC_TYPE_MSB:`SDDC_FC_TYPE_LSB] == `SDDC_FC_TYPE_SINC3);
    wire [14:0] n_raw   = direct ? cfg[14:0] :
                          {2'h0, cfg[`SDDC_FC_AVG_MSB:0]};
    wire [14:0] n       = (n_raw == 15'h0) ? 15'h1 : n_raw;
    wire [19:0] decim   = sinc3 ? {n, 5'h00} : `SDDC_SINC5_DEC;
    wire        restart = cfg_wr | (channel_i != chan_q);

    // ========================================================
    // CIC decimator, order five or three
    // ========================================================
    reg  [63:0] integ [0:4];
    reg  [63:0] dly   [0:4];
    reg  [63:0] cin   [0:4];
    reg  [63:0] cv;
    reg  [19:0] dcnt;
    reg  [63:0] acc;
    reg  [14:0] acnt;
    reg  [1:0]  ocnt;
    integer     k;
    integer     j;

    wire        dec_hit = mod_tick && (dcnt == decim - 20'h1);
    wire        avg_end = (acnt == n - 15'h1);
    assign      emit    = dec_hit & (sinc3 | avg_end);

    // ========================================================
    // Comb stages, three of the five used for sinc3
    // ========================================================
    always @* begin
        cv = sinc3 ? integ[2] : integ[4];
        for (j = 0; j < 5; j = j + 1) begin
            cin[j] = cv;
            if (j < 3 || !sinc3) begin
                cv = cv - dly[j];
            end
        end
    end

    // ========================================================
    // Integrators, decimation and sinc1 average
    // ========================================================
    always @(posedge clk_i) begin
        if (rst_i || restart) begin
            chan_q <= channel_i;
            dcnt   <= 20'h0;
            acc    <= 64'h0;
            acnt   <= 15'h0;
            for (k = 0; k < 5; k = k + 1) begin
                integ[k] <= 64'h0;
                dly[k]   <= 64'h0;
            end
        end else begin
            if (mod_tick) begin
                integ[0] <= integ[0] + {63'h0, mod_bit_i};
                for (k = 1; k < 5; k = k + 1) begin
                    integ[k] <= integ[k] + integ[k-1];
                end
                dcnt <= dec_hit ? 20'h0 : dcnt + 20'h1;
            end
            if (dec_hit) begin
                for (k = 0; k < 5; k = k + 1) begin
                    dly[k] <= cin[k];
                end
                if (!sinc3) begin
                    // Sinc1 stage averages sinc5 samples
                    acc  <= avg_end ? 64'h0 : acc + cv;
                    acnt <= avg_end ? 15'h0 : acnt + 15'h1;
                end
            end
        end
    end

    // ========================================================
    // Result, pulse and settle count
    // ========================================================
    // Results survive a restart; the settle count and the filter state start over
    always @(posedge clk_i) begin
        if (rst_i) begin
            result      <= 64'h0;
            result_chan <= 2'h0;
            settled_o   <= 1'b0;
        end else if (!restart && emit) begin
            result      <= sinc3 ? cv : acc + cv;
            result_chan <= chan_q;
            if (sinc3) begin
                settled_o <= (ocnt >= `SDDC_SINC3_SETTLE - 2'h1);
            end else begin
                settled_o <= (n >= `SDDC_SETTLE1_AVG) ||
                             (ocnt != 2'h0);
            end
        end
    end

    always @(posedge clk_i) begin
        if (rst_i || restart) begin
            ocnt         <= 2'h0;
            data_valid_o <= 1'b0;
        end else begin
            data_valid_o <= emit;
            if (emit && ocnt != `SDDC_SINC3_SETTLE) begin
                ocnt <= ocnt + 2'h1;
            end
        end
    end

endmodule

// file: sddc_props.sv
/* Port checker for sddc_top.
   Bound to every sddc_top; sees its ports only. */
`timescale 1ns/100ps
module sddc_props (
    input wire clk_i,             // Clock
    input wire rst_i,             // Reset
    input wire cyc_i,             // Cycle
    input wire stb_i,             // Strobe
    input wire we_i,              // Write
    input wire ack_o,             // Ack
    input wire int_osc_i,         // Oscillator
    input wire clock_io_pin_o,    // Pin level
    input wire clock_io_pin_oe_o, // Pin enable
    input wire data_valid_o,      // Result pulse
    input wire settled_o          // Settled
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    rst_quiet_a: assert property ($fell(rst_i) |->
        !clock_io_pin_oe_o && !settled_o && !ack_o && !data_valid_o)
        else $error("outputs not cleared by reset");
    pin_copy_a: assert property (clock_io_pin_oe_o && !$past(rst_i)
        |-> clock_io_pin_o == $past(int_osc_i))
        else $error("clock pin not following oscillator");
    oe_cause_a: assert property ($changed(clock_io_pin_oe_o) |->
        $past(rst_i) || $past(stb_i && we_i) || $past(stb_i && we_i, 2))
        else $error("pin enable changed without a write");
    ack_answer_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("request not answered");
    ack_once_a: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    ack_cause_a: assert property (ack_o |-> $past(cyc_i && stb_i))
        else $error("ack without request");
    dv_gap_a: assert property (data_valid_o |=> !data_valid_o [*8])
        else $error("results closer than the modulator allows");
    settle_dv_a: assert property ($rose(settled_o) |-> data_valid_o)
        else $error("settled rose without a result");
endmodule

bind sddc_top sddc_props i_sddc_props (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cyc_i(cyc_i),
    .stb_i(stb_i),
    .we_i(we_i),
    .ack_o(ack_o),
    .int_osc_i(int_osc_i),
    .clock_io_pin_o(clock_io_pin_o),
    .clock_io_pin_oe_o(clock_io_pin_oe_o),
    .data_valid_o(data_valid_o),
    .settled_o(settled_o)
);

// file: sddc_src_model.sv
/* Clock sources and modulator seen by sddc_top.
   Steps on each rising edge of the system clock. */
`timescale 1ns/100ps
module sddc_src_model (
    input  wire clk_i,       // System clock
    output wire int_osc_o,   // Oscillator, rises every 2 clocks
    output wire clock_pin_o, // Clock pin source, every 4 clocks
    output wire crystal_o,   // Crystal, every 8 clocks
    output wire mod_bit_o    // Modulator bit
);
    reg [2:0] cnt = 3'h0;

    always @(posedge clk_i) begin
        cnt <= cnt + 3'h1;
    end
    assign int_osc_o   = cnt[0];
    assign clock_pin_o = cnt[1];
    assign crystal_o   = cnt[2];
    assign mod_bit_o   = 1'b1;
endmodule

// file: tb.sv
/* Self-checking bench for sddc_top.
   Needs sddc_src_model and the bound sddc_props checker. */
`timescale 1ns/100ps
module tb;
    reg         clk_i = 1'b0;
    reg         rst_i = 1'b1;
    reg         cyc_i = 1'b0;
    reg         stb_i = 1'b0;
    reg         we_i  = 1'b0;
    reg  [7:0]  adr_i = 8'h00;
    reg  [31:0] dat_i = 32'h0;
    reg  [1:0]  chan  = 2'h0;
    wire [31:0] dat_o;
    wire        ack_o, osc, xtal, ext, mbit, pin_o, pin_oe, dv, settled;
    wire        pin_lvl = pin_oe ? pin_o : ext;
    reg  [31:0] rd;
    integer     mismatches = 0;
    integer     checked = 0;
    integer     cycles = 0;

    always #25 clk_i = ~clk_i;

    sddc_src_model i_sddc_src_model (.clk_i(clk_i), .int_osc_o(osc),
        .clock_pin_o(ext), .crystal_o(xtal), .mod_bit_o(mbit));
    sddc_top i_sddc_top (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
        .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(4'h3),
        .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .int_osc_i(osc),
        .crystal_input_pin_i(xtal), .clock_io_pin_i(pin_lvl),
        .clock_io_pin_o(pin_o), .clock_io_pin_oe_o(pin_oe),
        .mod_bit_i(mbit), .channel_i(chan), .data_valid_o(dv),
        .settled_o(settled));

    // ==========================================
    // Bus cycle, compare and verdict
    task close_out;
        begin
            if (mismatches == 0 && checked > 0) $display("ALL TESTS PASSED");
            else $display("TESTS FAILED");
            $finish;
        end
    endtask

    task chk(input string n, input [31:0] e, input [31:0] s);
        begin
            checked = checked + 1;
            if (s !== e) begin
                mismatches = mismatches + 1;
                $display("ERROR %s expected %h seen %h", n, e, s);
            end
        end
    endtask

    task wb(input w, input [7:0] a, input [31:0] d);
        begin
            cyc_i <= 1'b1;
            stb_i <= 1'b1;
            we_i  <= w;
            adr_i <= a;
            dat_i <= d;
            @(posedge clk_i);
            while (ack_o !== 1'b1) @(posedge clk_i);
            rd = dat_o;
            cyc_i <= 1'b0;
            stb_i <= 1'b0;
            @(posedge clk_i);
        end
    endtask

    // Select source and filter, then time three results
    task filt(input [1:0] src, input [1:0] ch, input [15:0] fc,
              input [31:0] per, input [2:0] st);
        integer n;
        integer k;
        begin
            chan <= ch;
            wb(1'b1, 8'h00, {28'h0, src, 2'h0});
            wb(1'b0, 8'h00, 32'h0);
            chk("mode", {28'h0, src, 2'h0}, rd);
            chk("pin_oe", {31'h0, src == 2'h1}, {31'h0, pin_oe});
            wb(1'b1, {4'h2, ch, 2'h0}, {16'h0, fc});
            for (k = 0; k < 3; k = k + 1) begin
                n = 0;
                @(posedge clk_i);
                while (dv !== 1'b1) begin
                    n = n + 1;
                    @(posedge clk_i);
                end
                chk("settled", {31'h0, st[k]}, {31'h0, settled});
                if (k > 0) chk("period", per, n + 1);
            end
            wb(1'b0, 8'h08, 32'h0);
            chk("status", {26'h0, ch, src, st[2], 1'b1}, rd);
            wb(1'b0, 8'h0c, 32'h0);
            wb(1'b0, 8'h08, 32'h0);
            chk("ready_clr", {26'h0, ch, src, st[2], 1'b0}, rd);
        end
    endtask

    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 50000) begin
            mismatches = mismatches + 1;
            close_out;
        end
    end

    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(1'b0, 8'h00, 32'h0);
        chk("mode_reset", 32'h0, rd);
        wb(1'b0, 8'h20, 32'h0);
        chk("fcfg_reset", 32'h19, rd);
        wb(1'b1, 8'h14, 32'hffff);
        wb(1'b0, 8'h14, 32'h0);
        chk("unmapped", 32'h0, rd);
        filt(2'h0, 2'h0, 16'h8001, 128, 3'b100);
        filt(2'h1, 2'h0, 16'h8002, 256, 3'b100);
        filt(2'h2, 2'h0, 16'h8001, 256, 3'b100);
        filt(2'h3, 2'h0, 16'h8001, 512, 3'b100);
        filt(2'h0, 2'h1, 16'h8002, 256, 3'b100);
        filt(2'h0, 2'h0, 16'h0001, 128, 3'b110);
        filt(2'h0, 2'h0, 16'h0019, 3200, 3'b111);
        filt(2'h0, 2'h0, 16'h6001, 128, 3'b100);
        filt(2'h0, 2'h0, 16'h8019, 3200, 3'b100);
        close_out;
    end
endmodule
